// ---- aiu_params.svh ----
// Purpose: constants of the audio io unit
// Assumes: clk_i at 100 MHz, byte offsets on an 8-bit wishbone address
// Notes: per-interface words at 0x80 + 16*i, capture words at 0x40 + 8*i
`ifndef AIU_PARAMS_SVH
`define AIU_PARAMS_SVH
// ==========================================
// timing
`define AIU_CLK_NS 10
`define AIU_TB_NS 40
`define AIU_TRK_LOG2 8
// ==========================================
// register offsets
`define AIU_CTRL_OFS 8'h00
`define AIU_TB_OFS 8'h04
`define AIU_START_OFS 8'h08
`define AIU_SCHED_OFS 8'h0c
`define AIU_STAT_OFS 8'h10
`define AIU_MUTE_OFS 8'h14
`define AIU_PDM_OFS 8'h18
`define AIU_TSEL_OFS 8'h1c
`define AIU_TRK0_OFS 8'h20
`define AIU_TRK1_OFS 8'h24
`define AIU_IRQCFG_OFS 8'h28
// ==========================================
// fields and reset values
`define AIU_CTRL_CLR 0
`define AIU_CTRL_ARM 1
`define AIU_CTRL_SEL 6:4
`define AIU_CTRL_CAP 8
`define AIU_CTRL_MASK 32'h0000_0072
`define AIU_ST_MODE 17:16
`define AIU_MODE_ABS 2'h1
`define AIU_MODE_REL 2'h2
`define AIU_PDM_DIV 7:0
`define AIU_PDM_HALF 8
`define AIU_PDM_FALL 9
`define AIU_PDM_CNT 10
`define AIU_PDM_EN 11
`define AIU_PDM_BPF 21:16
`define AIU_PDM_DLY 31:24
`define AIU_PDM_RST 32'h0020_0004
`define AIU_MUTE_PDM 11:8
`define AIU_MUTE_MASK 32'h0000_0f1f
`endif

// ---- aiu_pkg.sv ----
// Purpose: types of the audio io unit
// Assumes: nothing
// Notes: constants live in aiu_params.svh
package aiu_pkg;
  typedef logic [31:0] aiu_word_t;
  typedef enum {IF_IDLE, IF_WAIT, IF_RUN, IF_PAUSED} aiu_if_state_t;
endpackage

// ---- aiu_top.sv ----
// Purpose: audio io unit time base, frame scheduling, mute, pdm capture, rate tracking
// Assumes: 100 MHz clk_i, synchronous active high rst_i, classic wishbone slave
// Notes: frame_i and run_o face serial interface logic on the same clock
`timescale 1ns/10ps
`include "aiu_params.svh"
module aiu_top
#(
  parameter int N_IF = 6,
  parameter int N_PDM = 4
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire aiu_pkg::aiu_word_t wb_dat_i,
  output aiu_pkg::aiu_word_t wb_dat_o,
  output logic wb_ack_o,
  input wire logic [N_IF-1:0] frame_i,
  output logic [N_IF-1:0] run_o,
  output logic [N_IF-1:0] irq_period_o,
  output logic [N_IF-1:0] irq_pause_o,
  output logic [N_IF-1:0] irq_restart_o,
  input wire logic hw_silence_pad_i,
  input wire logic [7:0] gpio_pad_i,
  output logic [4:0] rx_mute_o,
  output logic pdm_clk_o,
  input wire logic [N_PDM-1:0] pdm_dat_i,
  output logic [2*N_PDM*32-1:0] pdm_word_o,
  output logic [2*N_PDM-1:0] pdm_valid_o,
  input wire logic [15:0] trk_src_i
);
  import aiu_pkg::*;

  localparam int TB_DIV = `AIU_TB_NS / `AIU_CLK_NS;
  localparam int NW = 2 * N_PDM;

  if (N_IF < 1 || N_IF > 8 || N_PDM < 1 || N_PDM > 4 || TB_DIV < 1)
  begin : g_bad
    $error("aiu_top: unsupported parameters");
  end

  function automatic aiu_word_t wmerge(input aiu_word_t old, input aiu_word_t nw, input logic [3:0] sel);
    aiu_word_t r;
    for (int b = 0; b < 4; b++)
      r[8*b +: 8] = sel[b] ? nw[8*b +: 8] : old[8*b +: 8];
    return r;
  endfunction

  function automatic logic rise(input logic [15:0] now, input logic [15:0] was, input logic [3:0] sel);
    return now[sel] & ~was[sel];
  endfunction

  // ==========================================
  // bus decode
  aiu_word_t ctrl_reg, sched_reg, mute_reg, pdm_reg, tsel_reg, irqcfg_reg, tb_reg, rd_word;
  logic [7:0] tdiv_reg;
  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wb_wr = wb_req & wb_we_i;
  wire [5:0] widx = wb_adr_i[7:2];
  wire [2:0] if_sel = widx[4:2];
  wire [1:0] if_fld = widx[1:0];
  wire [2:0] cap_sel = widx[3:1];
  wire wr_ctrl = wb_wr && wb_adr_i == `AIU_CTRL_OFS;
  wire wr_start = wb_wr && wb_adr_i == `AIU_START_OFS;
  wire wr_if = wb_wr & widx[5];
  wire tb_clr = wr_ctrl & wb_sel_i[0] & wb_dat_i[`AIU_CTRL_CLR];
  wire cap_all = wr_ctrl & wb_sel_i[1] & wb_dat_i[`AIU_CTRL_CAP];
  wire [7:0] start_mask = (wr_start & wb_sel_i[0]) ? wb_dat_i[7:0] : 8'h00;
  wire [7:0] pause_mask = (wr_start & wb_sel_i[1]) ? wb_dat_i[15:8] : 8'h00;
  wire [1:0] start_mode = wb_sel_i[2] ? wb_dat_i[`AIU_ST_MODE] : 2'h0;
  wire start_now = start_mode != `AIU_MODE_ABS && start_mode != `AIU_MODE_REL;
  wire [31:0] start_tgt = (start_mode == `AIU_MODE_REL) ? tb_reg + sched_reg : sched_reg;
  wire tb_tick = tdiv_reg == 8'(TB_DIV - 1);

  // ==========================================
  // input synchronisers
  logic hws1, hws2;
  logic [7:0] gp1, gp2, gp3;
  logic [N_PDM-1:0] pd1, pd2;
  logic [15:0] tsy1, tsy2, tsy3;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      {hws1, hws2} <= 2'h0;
      {gp1, gp2, gp3} <= 24'h0;
      pd1 <= '0;
      pd2 <= '0;
      {tsy1, tsy2, tsy3} <= 48'h0;
    end
    else
    begin
      hws1 <= hw_silence_pad_i;
      hws2 <= hws1;
      gp1 <= gpio_pad_i;
      gp2 <= gp1;
      gp3 <= gp2;
      pd1 <= pdm_dat_i;
      pd2 <= pd1;
      tsy1 <= trk_src_i;
      tsy2 <= tsy1;
      tsy3 <= tsy2;
    end
  end

  // ==========================================
  // configuration registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_reg <= '0;
      sched_reg <= '0;
      mute_reg <= '0;
      pdm_reg <= `AIU_PDM_RST;
      tsel_reg <= '0;
      irqcfg_reg <= '0;
    end
    else if (wb_wr)
    begin
      case (wb_adr_i)
        `AIU_CTRL_OFS: ctrl_reg <= wmerge(ctrl_reg, wb_dat_i, wb_sel_i) & `AIU_CTRL_MASK;
        `AIU_SCHED_OFS: sched_reg <= wmerge(sched_reg, wb_dat_i, wb_sel_i);
        `AIU_MUTE_OFS: mute_reg <= wmerge(mute_reg, wb_dat_i, wb_sel_i) & `AIU_MUTE_MASK;
        `AIU_PDM_OFS: pdm_reg <= wmerge(pdm_reg, wb_dat_i, wb_sel_i);
        `AIU_TSEL_OFS: tsel_reg <= wmerge(tsel_reg, wb_dat_i, wb_sel_i);
        `AIU_IRQCFG_OFS: irqcfg_reg <= wmerge(irqcfg_reg, wb_dat_i, wb_sel_i);
        default: ;
      endcase
    end
  end

  // ==========================================
  // time base and pad trigger
  logic pad_go_reg;
  wire pad_arm = ctrl_reg[`AIU_CTRL_ARM];
  wire [2:0] pad_sel = ctrl_reg[`AIU_CTRL_SEL];
  wire pad_rise = gp2[pad_sel] & ~gp3[pad_sel];
  wire count_en = ~pad_arm | pad_go_reg;

  always_ff @(posedge clk_i)
  begin
    if (rst_i | tb_clr)
    begin
      tdiv_reg <= 8'h00;
      tb_reg <= '0;
    end
    else
    begin
      tdiv_reg <= tb_tick ? 8'h00 : tdiv_reg + 8'h01;
      if (tb_tick)
        tb_reg <= tb_reg + 32'h1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i | ~pad_arm)
      pad_go_reg <= 1'b0;
    else if (pad_rise)
      pad_go_reg <= 1'b1;
  end

  // ==========================================
  // per-interface scheduling and counting
  aiu_if_state_t st_reg [N_IF];
  aiu_word_t fc_reg [N_IF];
  aiu_word_t ts_reg [N_IF];
  aiu_word_t per_reg [N_IF];
  aiu_word_t percnt_reg [N_IF];
  aiu_word_t pcnt_reg [N_IF];
  aiu_word_t since_reg [N_IF];
  aiu_word_t tgt_reg [N_IF];
  aiu_word_t capfc_reg [N_IF];
  aiu_word_t capts_reg [N_IF];
  logic [N_IF-1:0] now_reg, pcmd_reg, halt_reg, start_done_flag_reg, pause_hit, per_hit;
  wire [N_IF-1:0] framed = run_o & frame_i;
  wire [N_IF-1:0] counted = framed & {N_IF{count_en}};

  always_comb
  begin
    for (int i = 0; i < N_IF; i++)
    begin
      pause_hit[i] = pcnt_reg[i] != 32'h0 && since_reg[i] + 32'h1 == pcnt_reg[i];
      per_hit[i] = per_reg[i] != 32'h0 && percnt_reg[i] + 32'h1 == per_reg[i];
    end
  end

  always_ff @(posedge clk_i)
  begin
    for (int i = 0; i < N_IF; i++)
    begin
      if (rst_i)
      begin
        st_reg[i] <= IF_IDLE;
        run_o[i] <= 1'b0;
        {now_reg[i], pcmd_reg[i], halt_reg[i], start_done_flag_reg[i]} <= 4'h0;
        tgt_reg[i] <= '0;
        since_reg[i] <= '0;
        irq_pause_o[i] <= 1'b0;
        irq_restart_o[i] <= 1'b0;
      end
      else
      begin
        irq_pause_o[i] <= 1'b0;
        irq_restart_o[i] <= 1'b0;
        if (framed[i])
          since_reg[i] <= since_reg[i] + 32'h1;
        case (st_reg[i])
          IF_IDLE, IF_PAUSED:
            if (start_mask[i])
            begin
              st_reg[i] <= IF_WAIT;
              now_reg[i] <= start_now;
              tgt_reg[i] <= start_tgt;
            end
          IF_WAIT:
            if (now_reg[i] || tb_reg == tgt_reg[i])
            begin
              st_reg[i] <= IF_RUN;
              run_o[i] <= 1'b1;
              start_done_flag_reg[i] <= 1'b1;
              since_reg[i] <= '0;
              halt_reg[i] <= 1'b0;
              irq_restart_o[i] <= halt_reg[i] & irqcfg_reg[8+i];
            end
          IF_RUN:
            if (frame_i[i] && (pcmd_reg[i] || pause_hit[i]))
            begin
              st_reg[i] <= IF_PAUSED;
              run_o[i] <= 1'b0;
              halt_reg[i] <= 1'b1;
              pcmd_reg[i] <= 1'b0;
              irq_pause_o[i] <= irqcfg_reg[i];
            end
            else if (pause_mask[i])
              pcmd_reg[i] <= 1'b1;
          default: st_reg[i] <= IF_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    for (int i = 0; i < N_IF; i++)
    begin
      if (rst_i)
      begin
        {fc_reg[i], ts_reg[i], percnt_reg[i]} <= 96'h0;
        {per_reg[i], pcnt_reg[i], capfc_reg[i], capts_reg[i]} <= 128'h0;
        irq_period_o[i] <= 1'b0;
      end
      else
      begin
        irq_period_o[i] <= 1'b0;
        if (counted[i])
        begin
          fc_reg[i] <= fc_reg[i] + 32'h1;
          ts_reg[i] <= tb_reg;
          percnt_reg[i] <= per_hit[i] ? 32'h0 : percnt_reg[i] + 32'h1;
          irq_period_o[i] <= per_hit[i];
        end
        if (cap_all)
        begin
          capfc_reg[i] <= fc_reg[i];
          capts_reg[i] <= ts_reg[i];
        end
        if (wr_if && int'(if_sel) == i && if_fld == 2'h2)
          per_reg[i] <= wmerge(per_reg[i], wb_dat_i, wb_sel_i);
        if (wr_if && int'(if_sel) == i && if_fld == 2'h3)
          pcnt_reg[i] <= wmerge(pcnt_reg[i], wb_dat_i, wb_sel_i);
      end
    end
  end

  // ==========================================
  // pdm clock, sampling and word assembly
  logic [7:0] pdiv_reg, pdly_reg;
  logic parm_reg, pph_reg;
  logic [5:0] pbc_reg [2];
  logic [31:0] psh_reg [NW];
  wire p_en = pdm_reg[`AIU_PDM_EN];
  wire p_half = pdiv_reg == pdm_reg[`AIU_PDM_DIV];
  wire p_samp = parm_reg && pdly_reg == 8'h00;
  wire p_hc = pdm_reg[`AIU_PDM_HALF];
  wire p_take = p_samp && (p_hc || pph_reg == pdm_reg[`AIU_PDM_FALL]);
  wire p_ch = p_hc & pph_reg;
  wire p_done = p_take && pbc_reg[p_ch] + 6'h01 == pdm_reg[`AIU_PDM_BPF];
  wire [3:0] pdm_mute = mute_reg[`AIU_MUTE_PDM] | {4{hws2}};

  always_ff @(posedge clk_i)
  begin
    if (rst_i | ~p_en)
    begin
      pdiv_reg <= 8'h00;
      pdm_clk_o <= 1'b0;
      {parm_reg, pph_reg} <= 2'h0;
      pdly_reg <= 8'h00;
      pbc_reg[0] <= 6'h00;
      pbc_reg[1] <= 6'h00;
    end
    else
    begin
      pdiv_reg <= p_half ? 8'h00 : pdiv_reg + 8'h01;
      if (p_half)
      begin
        pdm_clk_o <= ~pdm_clk_o;
        parm_reg <= 1'b1;
        pph_reg <= pdm_clk_o;
        pdly_reg <= pdm_reg[`AIU_PDM_CNT] ? pdm_reg[`AIU_PDM_DLY] : 8'h00;
      end
      else if (p_samp)
        parm_reg <= 1'b0;
      else if (parm_reg)
        pdly_reg <= pdly_reg - 8'h01;
      if (p_take)
        pbc_reg[p_ch] <= p_done ? 6'h00 : pbc_reg[p_ch] + 6'h01;
    end
  end

  always_ff @(posedge clk_i)
  begin
    pdm_valid_o <= '0;
    if (rst_i)
      pdm_word_o <= '0;
    else if (p_take)
    begin
      for (int r = 0; r < N_PDM; r++)
      begin
        psh_reg[2*r + int'(p_ch)] <= {psh_reg[2*r + int'(p_ch)][30:0], pd2[r] & ~pdm_mute[r]};
        if (p_done)
        begin
          pdm_word_o[(2*r + int'(p_ch))*32 +: 32] <= {psh_reg[2*r + int'(p_ch)][30:0], pd2[r] & ~pdm_mute[r]};
          pdm_valid_o[2*r + int'(p_ch)] <= 1'b1;
        end
      end
    end
  end

  // ==========================================
  // rate phase trackers
  logic [31:0] trk_cnt_reg [2];
  logic [`AIU_TRK_LOG2-1:0] trk_ref_reg [2];
  aiu_word_t trk_ratio_reg [2];
  logic [1:0] trk_src_ev, trk_ref_ev;

  always_comb
  begin
    for (int t = 0; t < 2; t++)
    begin
      trk_src_ev[t] = rise(tsy2, tsy3, tsel_reg[8*t +: 4]);
      trk_ref_ev[t] = rise(tsy2, tsy3, tsel_reg[8*t+4 +: 4]);
    end
  end

  always_ff @(posedge clk_i)
  begin
    for (int t = 0; t < 2; t++)
    begin
      if (rst_i)
      begin
        trk_cnt_reg[t] <= '0;
        trk_ref_reg[t] <= '0;
        trk_ratio_reg[t] <= '0;
      end
      else
      begin
        if (trk_ref_ev[t])
          trk_ref_reg[t] <= trk_ref_reg[t] + {{(`AIU_TRK_LOG2-1){1'b0}}, 1'b1};
        if (trk_ref_ev[t] && trk_ref_reg[t] == '1)
        begin
          trk_ratio_reg[t] <= trk_cnt_reg[t] + {31'h0, trk_src_ev[t]};
          trk_cnt_reg[t] <= '0;
        end
        else if (trk_src_ev[t])
          trk_cnt_reg[t] <= trk_cnt_reg[t] + 32'h1;
      end
    end
  end

  // ==========================================
  // read data and answer
  always_comb
  begin
    rd_word = '0;
    if (widx[5])
    begin
      if (int'(if_sel) < N_IF)
        case (if_fld)
          2'h0: rd_word = fc_reg[if_sel];
          2'h1: rd_word = ts_reg[if_sel];
          2'h2: rd_word = per_reg[if_sel];
          default: rd_word = pcnt_reg[if_sel];
        endcase
    end
    else if (widx[4])
    begin
      if (int'(cap_sel) < N_IF)
        rd_word = widx[0] ? capts_reg[cap_sel] : capfc_reg[cap_sel];
    end
    else
      case (wb_adr_i)
        `AIU_CTRL_OFS: rd_word = ctrl_reg;
        `AIU_TB_OFS: rd_word = tb_reg;
        `AIU_SCHED_OFS: rd_word = sched_reg;
        `AIU_STAT_OFS: rd_word = {16'h0, 8'(halt_reg), 8'(start_done_flag_reg)};
        `AIU_MUTE_OFS: rd_word = {hws2, mute_reg[30:0]};
        `AIU_PDM_OFS: rd_word = pdm_reg;
        `AIU_TSEL_OFS: rd_word = tsel_reg;
        `AIU_TRK0_OFS: rd_word = trk_ratio_reg[0];
        `AIU_TRK1_OFS: rd_word = trk_ratio_reg[1];
        `AIU_IRQCFG_OFS: rd_word = irqcfg_reg;
        default: rd_word = '0;
      endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
      rx_mute_o <= 5'h00;
    end
    else
    begin
      wb_ack_o <= wb_req;
      if (wb_req)
        wb_dat_o <= rd_word;
      rx_mute_o <= mute_reg[4:0] | {2'h0, {3{hws2}}};
    end
  end

  // ==========================================
  // checks
  a_tb_step: assert property (@(posedge clk_i) disable iff (rst_i)
    tb_tick && !tb_clr |=> tb_reg == $past(tb_reg) + 32'h1)
    else $error("time base did not step");
  a_tb_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
    tb_tick && !tb_clr && tb_reg == 32'hffff_ffff |=> tb_reg == 32'h0)
    else $error("time base did not wrap");
  a_tb_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    tb_clr |=> tb_reg == 32'h0 ##1 tdiv_reg == 8'h01)
    else $error("time base not cleared");
  a_frame_count: assert property (@(posedge clk_i) disable iff (rst_i)
    counted[0] && !cap_all |=> fc_reg[0] == $past(fc_reg[0]) + 32'h1 && ts_reg[0] == $past(tb_reg))
    else $error("frame not counted or stamped");
  a_start_now: assert property (@(posedge clk_i) disable iff (rst_i)
    start_mask[0] && start_now && st_reg[0] == IF_IDLE |-> ##2 run_o[0] && start_done_flag_reg[0])
    else $error("immediate start missed");
  a_pause_edge: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(run_o[0]) |-> $past(frame_i[0]) && halt_reg[0])
    else $error("pause off a frame boundary");
  a_halt_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    st_reg[0] == IF_PAUSED |-> halt_reg[0] && !run_o[0])
    else $error("halted flag dropped while paused");
  a_period_irq: assert property (@(posedge clk_i) disable iff (rst_i)
    counted[0] && per_hit[0] |=> irq_period_o[0] && percnt_reg[0] == 32'h0)
    else $error("periodic interrupt missed");
  a_hw_mute: assert property (@(posedge clk_i) disable iff (rst_i)
    hws2 |=> rx_mute_o[2:0] == 3'h7)
    else $error("hardware mute not applied");
  a_pdm_clk: assert property (@(posedge clk_i) disable iff (rst_i)
    p_en && p_half && $past(p_en) |=> pdm_clk_o != $past(pdm_clk_o))
    else $error("pdm clock did not toggle");
  a_bus_ack: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
endmodule

// ---- aiu_pdm_mic.sv ----
// Purpose: microphone model on the pdm link
// Assumes: one level per microphone, held on both halves of the clock
// Notes: once the clock stands still the line no longer holds a valid level
`timescale 1ns/10ps
// ==========================================
// model
module aiu_pdm_mic
#(
  parameter logic [3:0] LEVEL = 4'h5
)
(
  input wire logic clk_i,
  input wire logic pdm_clk_i,
  output logic [3:0] pdm_dat_o
);
  logic last_reg = 1'b0;
  logic [3:0] junk_reg = 4'h3;
  int idle = 64;
  always @(posedge clk_i)
  begin
    if (pdm_clk_i !== last_reg) idle <= 0;
    else if (idle < 64) idle <= idle + 1;
    last_reg <= pdm_clk_i;
    junk_reg <= ~junk_reg;
  end
  // bit presented at the link clock rate on both edges, garbage when idle
  assign pdm_dat_o = (idle < 40) ? LEVEL : junk_reg;
endmodule

// ---- tb.sv ----
// Purpose: self-checking bench of the audio io unit
// Assumes: classic wishbone, 100 MHz clock, link clock of 160 ns
// Notes: a small model tracks frame counts and interrupts
`timescale 1ns/10ps
`include "aiu_params.svh"
module tb;
  import aiu_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  aiu_word_t dat = 32'h0, wb_dat_o, q, t;
  logic wb_ack_o, pdm_clk_o, pad = 1'b0, gate = 1'b1;
  logic [7:0] gp = 8'h00;
  logic [5:0] frame = 6'h0, run_o, irq_per, irq_pau, irq_rst;
  logic [4:0] rx_mute_o;
  logic [3:0] pdm_dat;
  logic [255:0] pdm_word_o;
  logic [7:0] pdm_valid_o;
  logic [15:0] trk = 16'h0;
  logic [31:0] lf = 32'h0001_2fac; // 77740
  int n_errors = 0, cmp_count = 0, m_cnt[6], n_per = 0, n_pau = 0, n_rst = 0, gap = 0, cnt = 0, n, n_v1 = 0;
  logic pc_last = 1'b0;
  // ==========================================
  // design and partner
  aiu_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .frame_i(frame), .run_o(run_o),
    .irq_period_o(irq_per), .irq_pause_o(irq_pau), .irq_restart_o(irq_rst), .hw_silence_pad_i(pad),
    .gpio_pad_i(gp), .rx_mute_o(rx_mute_o), .pdm_clk_o(pdm_clk_o), .pdm_dat_i(pdm_dat),
    .pdm_word_o(pdm_word_o), .pdm_valid_o(pdm_valid_o), .trk_src_i(trk));
  aiu_pdm_mic mic (.clk_i(clk_i), .pdm_clk_i(pdm_clk_o), .pdm_dat_o(pdm_dat));
  always #5 clk_i = ~clk_i;
  // ==========================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic check(input string nm, input aiu_word_t seen, input aiu_word_t exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input aiu_word_t d, input logic [3:0] s);
    int k;
    k = 0;
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= s;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (wb_ack_o !== 1'b1 && k < 50);
    if (k == 50) check("wb_ack", 0, 1);
    q = wb_dat_o;
    cyc <= 1'b0; stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic pulse(input int i);
    logic r;
    frame <= 6'h1 << i;
    #1 r = run_o[i];
    @(posedge clk_i);
    frame <= 6'h0;
    if (r === 1'b1 && gate) m_cnt[i]++;
    @(posedge clk_i);
  endtask
  task automatic pdm_wait();
    int k;
    repeat (3)
    begin
      k = 0;
      do
      begin
        @(posedge clk_i);
        #1 k++;
      end
      while (pdm_valid_o[0] !== 1'b1 && k < 400);
      if (k == 400) check("pdm_valid", 0, 1);
      @(posedge clk_i);
    end
  endtask
  task automatic results();
    $display("comparisons %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ==========================================
  // monitors
  always @(posedge clk_i)
  begin
    n_per += irq_per[0];
    n_pau += irq_pau[1];
    n_rst += irq_rst[1];
    n_v1 += pdm_valid_o[1];
    if (pdm_clk_o !== pc_last)
    begin
      gap = cnt + 1;
      cnt = 0;
    end
    else cnt++;
    pc_last = pdm_clk_o;
    lf <= lfsr(lf);
    trk <= lf[15:0];
  end
  initial
  begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    results();
  end
  // ==========================================
  // scenarios
  initial
  begin
    foreach (m_cnt[i]) m_cnt[i] = 0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(0, `AIU_PDM_OFS, 0, 4'hf); check("pdm_cfg_rst", q, `AIU_PDM_RST);
    wb(0, `AIU_STAT_OFS, 0, 4'hf); check("status_rst", q, 32'h0);
    wb(0, 8'hfc, 0, 4'hf); check("unmapped", q, 32'h0);
    wb(1, `AIU_CTRL_OFS, 32'h1, 4'hf);
    wb(0, `AIU_TB_OFS, 0, 4'hf); check("tb_clear", q < 4, 1);
    n = cmp_count; t = q;
    repeat (40) @(posedge clk_i);
    wb(0, `AIU_TB_OFS, 0, 4'hf); check("tb_rate", q - t >= 10 && q - t <= 12, 1);
    wb(1, 8'h88, 32'h3, 4'hf);
    wb(1, 8'h9c, 32'h2, 4'hf);
    wb(1, `AIU_IRQCFG_OFS, 32'h0202, 4'hf);
    wb(1, `AIU_START_OFS, 32'h0000_0003, 4'hf);
    repeat (2) @(posedge clk_i);
    check("run_both", run_o[1:0], 2'h3);
    wb(0, `AIU_STAT_OFS, 0, 4'hf); check("start_done_flag", q, 32'h3);
    n = 1 + lf % 7;
    repeat (n) pulse(0);
    wb(0, 8'h80, 0, 4'hf); check("count0", q, m_cnt[0]);
    check("irq_period", n_per, m_cnt[0] / 3);
    wb(0, 8'h84, 0, 4'hf); t = q;
    wb(0, `AIU_TB_OFS, 0, 4'hf); check("stamp", t <= q && q - t < 64, 1);
    wb(1, `AIU_CTRL_OFS, 32'h100, 4'hf);
    wb(0, 8'h40, 0, 4'hf); check("capture", q, m_cnt[0]);
    repeat (2) pulse(1);
    check("paused", run_o[1], 0);
    wb(0, `AIU_STAT_OFS, 0, 4'hf); check("halted", q[15:8], 8'h2);
    check("irq_pause", n_pau, 1);
    wb(1, `AIU_START_OFS, 32'h0000_0002, 4'hf);
    repeat (2) @(posedge clk_i);
    check("restart", run_o[1], 1);
    check("irq_restart", n_rst, 1);
    wb(0, `AIU_STAT_OFS, 0, 4'hf); check("unhalted", q[15:8], 8'h0);
    wb(1, `AIU_START_OFS, 32'h0000_0100, 4'hf);
    check("pend_only", run_o[0], 1);
    pulse(0);
    check("pause_cmd", run_o[0], 0);
    wb(1, `AIU_CTRL_OFS, 32'h32, 4'hf);
    wb(1, `AIU_START_OFS, 32'h4, 4'hf);
    repeat (2) @(posedge clk_i);
    gate = 1'b0;
    pulse(2);
    wb(0, 8'ha0, 0, 4'hf); check("pad_hold", q, m_cnt[2]);
    gp <= 8'h08;
    repeat (4) @(posedge clk_i);
    gate = 1'b1;
    pulse(2);
    wb(0, 8'ha0, 0, 4'hf); check("pad_go", q, m_cnt[2]);
    wb(1, `AIU_CTRL_OFS, 32'h0, 4'hf);
    wb(1, `AIU_SCHED_OFS, 32'h14, 4'hf);
    wb(1, `AIU_START_OFS, 32'h0002_0008, 4'hf);
    repeat (60) @(posedge clk_i);
    check("rel_wait", run_o[3], 0);
    repeat (30) @(posedge clk_i);
    check("rel_run", run_o[3], 1);
    wb(0, `AIU_TB_OFS, 0, 4'hf);
    wb(1, `AIU_SCHED_OFS, q + 32'h20, 4'hf);
    wb(1, `AIU_START_OFS, 32'h0001_0010, 4'hf);
    repeat (100) @(posedge clk_i);
    check("abs_wait", run_o[4], 0);
    repeat (40) @(posedge clk_i);
    check("abs_run", run_o[4], 1);
    pad <= 1'b1;
    repeat (6) @(posedge clk_i);
    check("hw_mute", rx_mute_o, 5'h07);
    pad <= 1'b0;
    wb(1, `AIU_MUTE_OFS, 32'h10, 4'hf);
    repeat (6) @(posedge clk_i);
    check("sw_mute", rx_mute_o, 5'h10);
    wb(1, `AIU_MUTE_OFS, 32'h400, 4'hf);
    wb(1, `AIU_PDM_OFS, 32'h0008_0907, 4'hf);
    pdm_wait();
    #1 check("pdm_ch0", pdm_word_o[7:0], 8'hff);
    check("pdm_ch1", pdm_word_o[39:32], 8'hff);
    check("pdm_ch2", pdm_word_o[71:64], 8'h00);
    check("pdm_mute", pdm_word_o[135:128], 8'h00);
    check("pdm_half", gap, 8);
    wb(1, `AIU_PDM_OFS, 32'h0308_0e07, 4'hf);
    n = n_v1;
    pdm_wait();
    check("pdm_classic", n_v1 - n, 0);
    check("pdm_delay", pdm_word_o[7:0], 8'hff);
    n = 0;
    do
    begin
      wb(0, `AIU_TRK0_OFS, 0, 4'hf);
      n++;
    end
    while (q == 32'h0 && n < 600);
    check("trk0_ratio", q, 32'h100);
    wb(0, `AIU_TRK1_OFS, 0, 4'hf); check("trk1_ratio", q, 32'h100);
    results();
  end
endmodule
